// ### verilog/stm_timer.sv
`timescale 1ns/1ps
module stm_timer
	import stm_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       rstn,
	input  wire logic [3:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic      [7:0] rdata,
	input  wire logic       ext_clk_pin,
	input  wire logic       capture_input_pin,
	output logic            timer_out
);
	import stm_pkg::*;

	// Pin synchronisers
	logic [1:0] ck_sync_q, cap_sync_q;
	logic       ck_last_q, cap_last_q;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ck_sync_q  <= 2'h0;
			cap_sync_q <= 2'h0;
			ck_last_q  <= 1'b0;
			cap_last_q <= 1'b0;
		end else begin
			ck_sync_q  <= {ck_sync_q[0], ext_clk_pin};
			cap_sync_q <= {cap_sync_q[0], capture_input_pin};
			ck_last_q  <= ck_sync_q[1];
			cap_last_q <= cap_sync_q[1];
		end
	end
	logic ck_rise, ck_fall, cap_rise, cap_fall;
	assign ck_rise  = ck_sync_q[1] & ~ck_last_q;
	assign ck_fall  = ~ck_sync_q[1] & ck_last_q;
	assign cap_rise = cap_sync_q[1] & ~cap_last_q;
	assign cap_fall = ~cap_sync_q[1] & cap_last_q;

	// Registers
	logic [7:0]       ctrl0_q, ctrl0_d, ctrl1_q, ctrl1_d;
	logic [CNT_W-1:0] cnt_q, cnt_d, cmpa_q, cmpa_d;
	logic [7:0]       wbuf_q, wbuf_d, rbuf_q, rbuf_d, rdata_d;
	logic             fa_q, fa_d, fp_q, fp_d, out_q, out_d, run_last_q;
	logic [PRE_W-1:0] pre_q, pre_d;

	logic       pause, run, run_rise, tick, clr_src, swap, oil, inv;
	logic [1:0] mode, pfs;
	logic [2:0] cks;
	logic [PER_W-1:0] per;
	assign pause   = ctrl0_q[C0_PAUSE];
	assign cks     = ctrl0_q[C0_CKS_LO +: 3];
	assign run     = ctrl0_q[C0_RUN];
	assign per     = ctrl0_q[C0_PER_LO +: PER_W];
	assign mode    = ctrl1_q[C1_MODE_LO +: 2];
	assign pfs     = ctrl1_q[C1_PFS_LO +: 2];
	assign oil     = ctrl1_q[C1_OIL];
	assign inv     = ctrl1_q[C1_INV];
	assign swap    = ctrl1_q[C1_SWAP];
	assign clr_src = ctrl1_q[C1_CLRSRC];
	assign run_rise = run & ~run_last_q;

	// Timer tick from prescaler, every mclk (code 001) or pin edge
	always_comb begin
		pre_d = pre_q + 8'h01;
		case (cks)
			3'h0:    tick = pre_q[1:0] == 2'h3;
			3'h1:    tick = 1'b1;
			3'h2:    tick = pre_q[3:0] == 4'hF;
			3'h3:    tick = pre_q[5:0] == 6'h3F;
			3'h4,
			3'h5:    tick = pre_q == 8'hFF;
			3'h6:    tick = ck_rise;
			default: tick = ck_fall;
		endcase
	end

	logic match_a, match_p, ovf, step, spulse, pwm_lvl;
	logic [CNT_W-1:0] duty, period_end;
	assign step    = run & ~pause & tick;
	assign match_a = step & (cnt_q == cmpa_q) & (cmpa_q != 10'h000);
	assign match_p = step & (per == 3'h0 ? cnt_q == 10'h3FF
		: cnt_q[CNT_W-1 -: PER_W] == per && cnt_q[6:0] == 7'h00);
	assign ovf     = step & (cnt_q == 10'h3FF);
	assign spulse  = mode == MODE_PWM && pfs == 2'h3;

	// PWM duty and period selection
	always_comb begin
		if (!swap) begin
			duty       = cmpa_q;
			period_end = {per, 7'h7F} ;
		end else begin
			duty       = {per, 7'h00};
			period_end = cmpa_q - 10'h001;
		end
		pwm_lvl = (cnt_q < duty) || (!swap && per == 3'h0 && cnt_q < duty);
		if (swap && per == 3'h0)
			pwm_lvl = 1'b1;
	end

	// Counter, flags, output and capture
	always_comb begin
		cnt_d  = cnt_q;
		fa_d   = fa_q;
		fp_d   = fp_q;
		out_d  = out_q;
		ctrl0_d = ctrl0_q;
		ctrl1_d = ctrl1_q;
		cmpa_d = cmpa_q;
		wbuf_d = wbuf_q;
		rbuf_d = rbuf_q;
		rdata_d = 8'h00;
		if (run_rise) begin
			cnt_d = '0;
			if (mode != MODE_CAP && mode != MODE_TMR)
				out_d = oil;
		end else if (step) begin
			cnt_d = cnt_q + 10'h001;
			case (mode)
				MODE_CMP, MODE_TMR: begin
					if (clr_src) begin
						if (match_a || ovf)
							cnt_d = '0;
					end else if (match_p || (per == 3'h0 && ovf))
						cnt_d = '0;
					if (mode == MODE_CMP && match_a) begin
						case (pfs)
							2'h1:    out_d = 1'b0;
							2'h2:    out_d = 1'b1;
							2'h3:    out_d = ~out_q;
							default: out_d = out_q;
						endcase
					end
				end
				MODE_PWM: begin
					if (spulse) begin
						if (match_a) begin
							out_d = ~oil;
							ctrl0_d[C0_RUN] = 1'b0;
						end
					end else if (swap ? cnt_q == period_end : (per == 3'h0 ? ovf : match_p))
						cnt_d = '0;
				end
				MODE_CAP: begin
					if (match_p)
						cnt_d = '0;
				end
				default: cnt_d = cnt_q;
			endcase
		end
		if (match_a && !(mode == MODE_CAP))
			fa_d = 1'b1;
		if (match_p && !(mode == MODE_CMP || mode == MODE_TMR) && mode != MODE_PWM)
			fp_d = 1'b1;
		if (match_p && (mode == MODE_PWM || !clr_src))
			fp_d = 1'b1;
		// Capture latches counter into compare A
		if (mode == MODE_CAP && run) begin
			if ((pfs == 2'h0 && cap_rise) || (pfs == 2'h1 && cap_fall)
				|| (pfs == 2'h2 && (cap_rise || cap_fall))) begin
				cmpa_d = cnt_q;
				fa_d   = 1'b1;
			end
		end
		// Register writes
		if (wr) begin
			case (addr)
				ADDR_CTRL0:   ctrl0_d = wdata;
				ADDR_CTRL1:   ctrl1_d = wdata;
				ADDR_CMPA_LO: wbuf_d = wdata;
				ADDR_CMPA_HI: cmpa_d = {wdata[1:0], wbuf_q};
				ADDR_FLAGS: begin // Write 1 clears, a same-cycle set wins only while the flag is still clear
					if (wdata[FL_A] && !(fa_d && !fa_q))
						fa_d = 1'b0;
					if (wdata[FL_P] && !(fp_d && !fp_q))
						fp_d = 1'b0;
				end
				default: ;
			endcase
		end
		// Register reads
		if (rd) begin
			case (addr)
				ADDR_CTRL0:   rdata_d = ctrl0_q;
				ADDR_CTRL1:   rdata_d = ctrl1_q;
				ADDR_CNT_LO:  rdata_d = rbuf_q;
				ADDR_CNT_HI: begin
					rdata_d = {6'h00, cnt_q[9:8]};
					rbuf_d  = cnt_q[7:0];
				end
				ADDR_CMPA_LO: rdata_d = rbuf_q;
				ADDR_CMPA_HI: begin
					rdata_d = {6'h00, cmpa_q[9:8]};
					rbuf_d  = cmpa_q[7:0];
				end
				ADDR_FLAGS:   rdata_d = {6'h00, fp_q, fa_q};
				default:      rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ctrl0_q    <= CTRL_RESET;
			ctrl1_q    <= CTRL_RESET;
			cnt_q      <= '0;
			cmpa_q     <= '0;
			wbuf_q     <= 8'h00;
			rbuf_q     <= 8'h00;
			rdata      <= 8'h00;
			fa_q       <= 1'b0;
			fp_q       <= 1'b0;
			out_q      <= 1'b0;
			run_last_q <= 1'b0;
			pre_q      <= '0;
		end else begin
			ctrl0_q    <= ctrl0_d;
			ctrl1_q    <= ctrl1_d;
			cnt_q      <= cnt_d;
			cmpa_q     <= cmpa_d;
			wbuf_q     <= wbuf_d;
			rbuf_q     <= rbuf_d;
			rdata      <= rdata_d;
			fa_q       <= fa_d;
			fp_q       <= fp_d;
			out_q      <= out_d;
			run_last_q <= run;
			pre_q      <= pre_d;
		end
	end

	// Output pin stage
	logic pin_d, pin_q;
	always_comb begin
		pin_d = 1'b0;
		case (mode)
			MODE_PWM: begin
				case (pfs)
					2'h0:    pin_d = ~oil;
					2'h1:    pin_d = oil;
					2'h2:    pin_d = run ? (pwm_lvl ? oil : ~oil) : ~oil;
					default: pin_d = out_q;
				endcase
				pin_d = pin_d ^ inv;
			end
			MODE_CMP: pin_d = out_q ^ inv;
			default:  pin_d = 1'b0;
		endcase
	end
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			pin_q <= 1'b0;
		else
			pin_q <= pin_d;
	end
	assign timer_out = pin_q;

	// Flag checks
	flag_a_sticky_a: assert property (@(posedge mclk) disable iff (!rstn)
		fa_q && !(wr && addr == ADDR_FLAGS && wdata[FL_A]) |=> fa_q)
		else $error("match A flag dropped without a clear");
	flag_p_sticky_a: assert property (@(posedge mclk) disable iff (!rstn)
		fp_q && !(wr && addr == ADDR_FLAGS && wdata[FL_P]) |=> fp_q)
		else $error("match P flag dropped without a clear");
	flag_set_wins_a: assert property (@(posedge mclk) disable iff (!rstn)
		match_a && mode != MODE_CAP |=> fa_q)
		else $error("match A flag lost on a same-cycle clear");
	p_flag_cmp_a: assert property (@(posedge mclk) disable iff (!rstn)
		mode == MODE_CMP && !clr_src && match_p |=> fp_q)
		else $error("P flag missing with P clear source");
	cmp_no_p_a: assert property (@(posedge mclk) disable iff (!rstn)
		mode == MODE_CMP && clr_src && !fp_q && !(wr && addr == ADDR_CTRL1) |=> !fp_q)
		else $error("P flag raised with A clear source");
	zero_a_flag_a: assert property (@(posedge mclk) disable iff (!rstn)
		cmpa_q == 10'h000 && !fa_q && mode == MODE_CMP |=> !fa_q)
		else $error("A flag raised with zero compare");
	cap_off_a: assert property (@(posedge mclk) disable iff (!rstn)
		mode == MODE_CAP && pfs == 2'h3 && !fa_q && !(wr && addr == ADDR_CTRL1) |=> !fa_q)
		else $error("capture taken while disabled");

	// Counter checks
	run_rise_clr_a: assert property (@(posedge mclk) disable iff (!rstn)
		$rose(run) |=> cnt_q == 10'h000 || cnt_q == 10'h001)
		else $error("counter not cleared by run rising");
	run_off_hold_a: assert property (@(posedge mclk) disable iff (!rstn)
		!run && !run_rise |=> $stable(cnt_q) || $past(run))
		else $error("counter moved while stopped");
	pause_hold_a: assert property (@(posedge mclk) disable iff (!rstn)
		run && pause && !run_rise |=> $stable(cnt_q))
		else $error("counter moved while paused");
	count_step_a: assert property (@(posedge mclk) disable iff (!rstn)
		step && !run_rise && mode == MODE_CMP && !clr_src && per == 3'h0 && cnt_q != 10'h3FF
		|=> cnt_q == $past(cnt_q) + 10'h001)
		else $error("counter did not step on a tick");
	clr_a_match_a: assert property (@(posedge mclk) disable iff (!rstn)
		mode == MODE_CMP && clr_src && match_a && !run_rise |=> cnt_q == 10'h000)
		else $error("A match did not clear the counter");
	clr_p_match_a: assert property (@(posedge mclk) disable iff (!rstn)
		mode == MODE_CMP && !clr_src && step && per != 3'h0 && cnt_q == {per, 7'h00} && !run_rise
		|=> cnt_q == 10'h000)
		else $error("P match did not clear the counter");

	// Register checks
	hi_read_a: assert property (@(posedge mclk) disable iff (!rstn)
		rd && addr == ADDR_CNT_HI |=> rdata[7:2] == 6'h00 && rbuf_q == $past(cnt_q[7:0]))
		else $error("counter high read wrong");
	cmpa_hi_read_a: assert property (@(posedge mclk) disable iff (!rstn)
		rd && addr == ADDR_CMPA_HI |=> rdata == {6'h00, $past(cmpa_q[9:8])})
		else $error("compare high read wrong");
	lo_read_a: assert property (@(posedge mclk) disable iff (!rstn)
		rd && addr == ADDR_CNT_LO |=> rdata == $past(rbuf_q))
		else $error("low read not from snapshot");
	cmp_a_lo_a: assert property (@(posedge mclk) disable iff (!rstn)
		wr && addr == ADDR_CMPA_LO |=> $stable(cmpa_q) || $past(mode) == MODE_CAP)
		else $error("low write reached compare value");
	cmp_a_hi_a: assert property (@(posedge mclk) disable iff (!rstn)
		wr && addr == ADDR_CMPA_HI && mode != MODE_CAP |=> cmpa_q == {$past(wdata[1:0]), $past(wbuf_q)})
		else $error("high write did not commit both bytes");

	// Output and single-pulse stop checks
	cmp_hold_pin_a: assert property (@(posedge mclk) disable iff (!rstn)
		mode == MODE_CMP && pfs == 2'h0 && !run_rise |=> $stable(out_q))
		else $error("output changed with no-change function");
	cmp_set_high_a: assert property (@(posedge mclk) disable iff (!rstn)
		mode == MODE_CMP && pfs == 2'h2 && match_a && !run_rise |=> out_q)
		else $error("output not driven high on A match");
	p_no_pin_a: assert property (@(posedge mclk) disable iff (!rstn)
		mode == MODE_CMP && match_p && !match_a && !run_rise |=> $stable(out_q))
		else $error("P match moved the output");
	run_init_a: assert property (@(posedge mclk) disable iff (!rstn)
		run_rise && mode == MODE_CMP |=> out_q == $past(oil))
		else $error("output not returned to initial level");
	cmp_invert_a: assert property (@(posedge mclk) disable iff (!rstn)
		mode == MODE_CMP |=> timer_out == ($past(out_q) ^ $past(inv)))
		else $error("output polarity wrong");
	pwm_force_a: assert property (@(posedge mclk) disable iff (!rstn)
		mode == MODE_PWM && pfs == 2'h1
		|=> ##1 timer_out == ($past(oil) ^ $past(inv)) || $past(mode) != MODE_PWM || $past(pfs) != 2'h1)
		else $error("forced active level wrong");
	pulse_end_a: assert property (@(posedge mclk) disable iff (!rstn)
		spulse && match_a && !run_rise && !(wr && addr == ADDR_CTRL0) |=> !run)
		else $error("single pulse did not stop the timer");
	tmr_pin_a: assert property (@(posedge mclk) disable iff (!rstn)
		mode == MODE_TMR |=> timer_out == 1'b0)
		else $error("pin driven in timer mode");

	cov_match_a_c: cover property (@(posedge mclk) disable iff (!rstn) match_a && mode == MODE_CMP);
	cov_match_p_c: cover property (@(posedge mclk) disable iff (!rstn) match_p && mode == MODE_CMP);
	cov_pulse_c: cover property (@(posedge mclk) disable iff (!rstn) spulse && match_a);
	cov_cap_c: cover property (@(posedge mclk) disable iff (!rstn) mode == MODE_CAP && cap_rise);
	cov_pin_tick_c: cover property (@(posedge mclk) disable iff (!rstn) step && cks[2:1] == 2'h3);
endmodule

// ### verilog/stm_pkg.sv
package stm_pkg;
	// Register map (byte offsets)
	localparam logic [3:0] ADDR_CTRL0   = 4'h0;
	localparam logic [3:0] ADDR_CTRL1   = 4'h1;
	localparam logic [3:0] ADDR_CNT_LO  = 4'h2;
	localparam logic [3:0] ADDR_CNT_HI  = 4'h3;
	localparam logic [3:0] ADDR_CMPA_LO = 4'h4;
	localparam logic [3:0] ADDR_CMPA_HI = 4'h5;
	localparam logic [3:0] ADDR_FLAGS   = 4'h6;
	// Control 0 fields
	localparam int C0_PAUSE = 7;
	localparam int C0_CKS_LO = 4;
	localparam int C0_RUN   = 3;
	localparam int C0_PER_LO = 0;
	// Control 1 fields
	localparam int C1_MODE_LO = 6;
	localparam int C1_PFS_LO  = 4;
	localparam int C1_OIL     = 3;
	localparam int C1_INV     = 2;
	localparam int C1_SWAP    = 1;
	localparam int C1_CLRSRC  = 0;
	// Flag register fields
	localparam int FL_A = 0;
	localparam int FL_P = 1;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam int CNT_W = 10;
	localparam int PER_W = 3;
	localparam logic [1:0] MODE_CMP = 2'h0;
	localparam logic [1:0] MODE_CAP = 2'h1;
	localparam logic [1:0] MODE_PWM = 2'h2;
	localparam logic [1:0] MODE_TMR = 2'h3;
	// Clock-select divide ratios for codes 000 and 010..101
	localparam int DIV_SYS4  = 4;
	localparam int DIV_H16   = 16;
	localparam int DIV_H64   = 64;
	localparam int DIV_TB    = 256;
	localparam int PRE_W     = 8;
endpackage

// ### sim/stm_far_side.sv
`timescale 1ns/1ps
module stm_far_side (
	input  wire logic mclk,
	input  wire logic timer_out,
	output logic      capture_input_pin,
	output logic      ext_clk_pin
);
	// Pins idle until a task drives them
	initial begin
		capture_input_pin = 1'b0;
		ext_clk_pin       = 1'b0;
	end
	// Sensor line moves just after a clock edge
	task automatic drive_cap(input logic lvl);
		@(posedge mclk);
		capture_input_pin <= lvl;
	endtask
	// Count clock pin: n full pulses, four cycles per level
	task automatic pulse_clk(input int n);
		repeat (n) begin
			repeat (4) @(posedge mclk);
			ext_clk_pin <= 1'b1;
			repeat (4) @(posedge mclk);
			ext_clk_pin <= 1'b0;
		end
	endtask
endmodule

// ### sim/tb.sv
`timescale 1ns/1ps
module tb;
	import stm_pkg::*;
	logic        mclk, rstn, wr, rd, timer_out, cap_pin, ext_pin, oil, inv;
	logic [3:0]  addr;
	logic [7:0]  wdata, rdata;
	logic [9:0]  cmpa;
	logic [15:0] v, c;
	logic [1:0]  pfs;
	int          fail_count, n_compared;
	stm_timer dut (.mclk(mclk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.ext_clk_pin(ext_pin), .capture_input_pin(cap_pin), .timer_out(timer_out));
	stm_far_side far (.mclk(mclk), .timer_out(timer_out), .capture_input_pin(cap_pin), .ext_clk_pin(ext_pin));
	always #5 mclk = ~mclk;
	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic bus(input logic w, input logic r, input logic [3:0] a, input logic [7:0] d);
		wr    <= w;
		rd    <= r;
		addr  <= a;
		wdata <= d;
		@(posedge mclk);
	endtask
	task automatic idle(input int n);
		repeat (n) bus(1'b0, 1'b0, 4'h0, 8'h00);
	endtask
	task automatic rd8(input logic [3:0] a, output logic [7:0] q);
		bus(1'b0, 1'b1, a, 8'h00);
		rd <= 1'b0;
		@(negedge mclk);
		q = rdata;
		@(posedge mclk);
	endtask
	// High part first so the low byte comes from the snapshot
	task automatic rd16(input logic [3:0] a, output logic [15:0] q);
		rd8(a + 4'h1, q[15:8]);
		rd8(a, q[7:0]);
	endtask
	task automatic start(input logic [7:0] c1, input logic [9:0] a, input logic [2:0] per);
		bus(1'b1, 1'b0, ADDR_CTRL0, 8'h10);
		bus(1'b1, 1'b0, ADDR_CMPA_LO, a[7:0]);
		bus(1'b1, 1'b0, ADDR_CMPA_HI, {6'h3F, a[9:8]});
		bus(1'b1, 1'b0, ADDR_CTRL1, c1);
		bus(1'b1, 1'b0, ADDR_FLAGS, 8'h03);
		bus(1'b1, 1'b0, ADDR_CTRL0, {5'h03, per});
		idle(5);
	endtask
	task automatic wait_out(input logic e, input int lim);
		int k;
		k = 0;
		while (timer_out !== e && k < lim) begin
			idle(1);
			k++;
		end
		chk("timer_out", {15'h0, e}, {15'h0, timer_out});
	endtask
	function automatic logic exp_out(input logic [1:0] f, input logic o, input logic n, input logic hit);
		logic l;
		case (f)
			2'h1: l = 1'b0;
			2'h2: l = 1'b1;
			2'h3: l = ~o;
			default: l = o;
		endcase
		return (hit ? l : o) ^ n;
	endfunction
	initial begin
		repeat (100000) @(posedge mclk);
		fail_count++;
		conclude();
	end
	initial begin
		mclk = 1'b0;
		rstn = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 4'h0;
		wdata = 8'h00;
		fail_count = 0;
		n_compared = 0;
		void'($urandom(22));
		repeat (3) @(posedge mclk);
		rstn <= 1'b1;
		idle(1);
		rd16(ADDR_CNT_LO, v);
		chk("counter", 16'h0000, v);
		rd16(ADDR_CMPA_LO, v);
		chk("compare_a", 16'h0000, v);
		rd8(4'h7, v[7:0]);
		chk("unmapped", 16'h0000, {8'h00, v[7:0]});
		cmpa = 10'($urandom_range(1023, 1));
		bus(1'b1, 1'b0, ADDR_CMPA_LO, cmpa[7:0]);
		bus(1'b1, 1'b0, ADDR_CMPA_HI, {6'h3F, cmpa[9:8]});
		idle(1);
		rd16(ADDR_CMPA_LO, v);
		chk("compare_a", {6'h00, cmpa}, v);
		$display("test registers done");
		for (int i = 0; i < 4; i++) begin
			pfs  = 2'(i);
			oil  = 1'($urandom);
			inv  = 1'($urandom);
			cmpa = 10'($urandom_range(100, 16));
			start({MODE_CMP, pfs, oil, inv, 2'b00}, cmpa, 3'h0);
			chk("initial level", {15'h0, exp_out(pfs, oil, inv, 1'b0)}, {15'h0, timer_out});
			wait_out(exp_out(pfs, oil, inv, 1'b1), 120);
			idle(100);
			rd8(ADDR_FLAGS, v[7:0]);
			chk("flags", 16'h0001, {14'h0, v[1:0]});
		end
		$display("test compare output done");
		for (int i = 0; i < 3; i++) begin
			cmpa = (i == 0) ? 10'($urandom_range(100, 16)) : (i == 1) ? 10'($urandom_range(400, 200)) : 10'h000;
			start({7'h00, i == 1}, cmpa, (i == 2) ? 3'h0 : 3'h1);
			idle(1100);
			rd8(ADDR_FLAGS, v[7:0]);
			chk("flags", (i == 0) ? 16'h3 : (i == 1) ? 16'h1 : 16'h2, {14'h0, v[1:0]});
			rd16(ADDR_CNT_LO, c);
			chk("count bound", 16'h1, {15'h0, c[9:0] <= ((i == 1) ? cmpa : (i == 0) ? 10'd127 : 10'h3FF)});
		end
		$display("test clear source done");
		bus(1'b1, 1'b0, ADDR_CTRL0, 8'h10);
		rd16(ADDR_CNT_LO, v);
		idle(20);
		rd16(ADDR_CNT_LO, c);
		chk("held count", v, c);
		bus(1'b1, 1'b0, ADDR_CTRL0, 8'h98);
		idle(20);
		rd16(ADDR_CNT_LO, c);
		chk("paused count", 16'h0000, c);
		bus(1'b1, 1'b0, ADDR_CTRL0, 8'h18);
		idle(20);
		rd16(ADDR_CNT_LO, c);
		chk("counting", 16'h1, {15'h0, c > 16'd15 && c < 16'd40});
		$display("test run and pause done");
		for (int i = 0; i < 2; i++) begin
			oil = 1'($urandom);
			start({MODE_PWM, 2'(i), oil, 3'h0}, 10'h040, 3'h1);
			chk("forced level", {15'h0, (i == 1) ~^ oil}, {15'h0, timer_out});
		end
		$display("test forced level done");
		for (int i = 0; i < 4; i++) begin
			start({MODE_CAP, 2'(i), 4'h0}, 10'h000, 3'h0);
			far.drive_cap(1'b1);
			idle(6);
			rd8(ADDR_FLAGS, v[7:0]);
			chk("capture on rise", {15'h0, i == 0 || i == 2}, {15'h0, v[0]});
			bus(1'b1, 1'b0, ADDR_FLAGS, 8'h03);
			idle(1);
			far.drive_cap(1'b0);
			idle(6);
			rd8(ADDR_FLAGS, v[7:0]);
			chk("capture on fall", {15'h0, i == 1 || i == 2}, {15'h0, v[0]});
		end
		$display("test capture done");
		for (int j = 0; j < 2; j++) begin
			bus(1'b1, 1'b0, ADDR_CTRL0, {1'b0, 3'(6 + j), 4'h0});
			bus(1'b1, 1'b0, ADDR_CTRL0, {1'b0, 3'(6 + j), 4'h8});
			idle(1);
			far.pulse_clk(10);
			idle(6);
			rd16(ADDR_CNT_LO, c);
			chk("pin clock count", 16'd10, c);
		end
		$display("test pin clock done");
		conclude();
	end
endmodule
